// >>> dtc_terminal.v
// Purpose: decode level-sensitive terminal commands of a motor drive and apply their effects
// Assumes: terminal inputs synchronous to clk_i; classic wishbone register access
// Notes: eight terminals, each given an assignment code by software
`timescale 1ns/10ps
`include "dtc_map.vh"

module dtc_terminal #(
  parameter NTERM = 8
) (
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset, active high
  input wire [NTERM-1:0] term_i, // digital input terminals
  input wire forward_run_i, // run command
  input wire drive_stopped_i, // motor speed reached zero
  input wire [31:0] wb_adr_i, // wishbone address
  input wire [31:0] wb_dat_i, // wishbone write data
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire wb_we_i, // wishbone write enable
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  output reg irq_o, // level interrupt
  output reg pid_enable_o, // pid control active
  output reg analog_inverse_o, // analog source 1 inverse direction
  output reg pid_inverse_o, // pid output inverse direction
  output reg power_loss_flag_o, // momentary power failure seen
  output reg link_priority_o, // link commands have priority
  output reg speed_search_o, // search idling speed this run
  output reg forced_decel_o, // decelerate with forced-stop time
  output reg forced_stop_alarm_o, // forced-stop alarm state
  output reg pid_clear_o, // reset integral and differential terms
  output reg pid_integral_freeze_o, // hold integral term
  output reg local_select_o, // local run and frequency sources
  output reg run_request_seen_o, // run command entered
  output reg drive_run_o // drive running
);

  // return the terminal level carrying a code, and whether any terminal carries it
  function [1:0] dtc_find;
    input [8*NTERM-1:0] codes;
    input [NTERM-1:0] lv;
    input [7:0] code;
    integer k;
    begin
      dtc_find = 2'b00;
      for (k = 0; k < NTERM; k = k + 1) begin
        if (codes[8*k +: 8] == code) begin
          dtc_find = {1'b1, dtc_find[0] | lv[k]};
        end
      end
    end
  endfunction

  reg [NTERM-1:0] term_r;
  reg [8*NTERM-1:0] assign_r;
  reg [31:0] cfg_r;
  reg [`DTC_IRQ_W-1:0] irq_stat_r;
  reg [`DTC_IRQ_W-1:0] irq_mask_r;
  reg alarm_clr_r;
  reg run_prev_r;
  reg [31:0] rd_nxt;
  reg [NTERM-1:0] mon_nxt;
  integer j;
  integer m;

  wire [1:0] f_bypass = dtc_find(assign_r, term_r, `DTC_CODE_PID_BYPASS);
  wire [1:0] f_invert = dtc_find(assign_r, term_r, `DTC_CODE_DIR_INVERT);
  wire [1:0] f_loss = dtc_find(assign_r, term_r, `DTC_CODE_POWER_LOSS);
  wire [1:0] f_link = dtc_find(assign_r, term_r, `DTC_CODE_LINK_PRIO);
  wire [1:0] f_search = dtc_find(assign_r, term_r, `DTC_CODE_SPEED_SEARCH);
  wire [1:0] f_stop = dtc_find(assign_r, term_r, `DTC_CODE_FORCED_STOP);
  wire [1:0] f_clear = dtc_find(assign_r, term_r, `DTC_CODE_PID_CLEAR);
  wire [1:0] f_freeze = dtc_find(assign_r, term_r, `DTC_CODE_PID_FREEZE);
  wire [1:0] f_local = dtc_find(assign_r, term_r, `DTC_CODE_KEYPAD_SEL);
  wire [1:0] f_permit = dtc_find(assign_r, term_r, `DTC_CODE_RUN_PERMIT);

  wire pid_on = ~f_bypass[0];
  wire manual_dir = cfg_r[`DTC_CFG_MANUAL_DIR];
  wire [1:0] pid_mode = cfg_r[`DTC_CFG_PID_MODE_HI:`DTC_CFG_PID_MODE_LO];
  // second source or up/down path is not subject to inversion
  wire other_path = cfg_r[`DTC_CFG_SECOND_SRC] | cfg_r[`DTC_CFG_UPDOWN];
  wire inv_eff = f_invert[0] & ~other_path;
  // bypassed pid: manual setting alone, invert ignored
  wire ana_dir = pid_on ? (manual_dir ^ inv_eff) : manual_dir;
  wire pid_dir = (pid_mode == `DTC_PID_INVERSE) ^ f_invert[0];
  wire link_lv = f_link[1] ? f_link[0] : 1'b1;
  // a stop terminal not assigned reads as released
  wire stop_req = f_stop[1] & ~f_stop[0];
  wire alarm_nxt = (forced_stop_alarm_o | (forced_decel_o & drive_stopped_i)) & ~alarm_clr_r;
  wire run_ok = forward_run_i & (~f_permit[1] | f_permit[0]) & ~stop_req & ~alarm_nxt;
  wire [`DTC_IRQ_W-1:0] ev = {forward_run_i & ~run_request_seen_o & f_permit[1],
                               f_loss[0] & ~power_loss_flag_o,
                               alarm_nxt & ~forced_stop_alarm_o};
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire [7:0] adr = wb_adr_i[7:0];

  // terminals captured once so every effect changes on an edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      term_r <= {NTERM{1'b0}};
    end else begin
      term_r <= term_i;
    end
  end

  // monitor-only terminals, visible on the bus, feeding nothing else
  always @* begin
    mon_nxt = {NTERM{1'b0}};
    for (j = 0; j < NTERM; j = j + 1) begin
      if (assign_r[8*j +: 8] == `DTC_CODE_MONITOR) begin
        mon_nxt[j] = term_r[j];
      end
    end
  end

  // read mux; unmapped reads return zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (adr)
      `DTC_REG_ASSIGN0: rd_nxt = assign_r[31:0];
      `DTC_REG_ASSIGN1: rd_nxt = assign_r[8*NTERM-1:32];
      `DTC_REG_CONFIG: rd_nxt = cfg_r;
      `DTC_REG_STATE: rd_nxt = {19'h0, drive_run_o, run_request_seen_o, local_select_o,
                               pid_integral_freeze_o, pid_clear_o, forced_stop_alarm_o,
                               forced_decel_o, speed_search_o, link_priority_o,
                               power_loss_flag_o, pid_inverse_o, analog_inverse_o,
                               pid_enable_o};
      `DTC_REG_MONITOR: rd_nxt = {{(32-NTERM){1'b0}}, mon_nxt};
      `DTC_REG_IRQ_STAT: rd_nxt = {{(32-`DTC_IRQ_W){1'b0}}, irq_stat_r};
      `DTC_REG_IRQ_MASK: rd_nxt = {{(32-`DTC_IRQ_W){1'b0}}, irq_mask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus slave: one wait state, ack for one cycle, every address acked
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      assign_r <= {8*NTERM{1'b0}};
      cfg_r <= `DTC_CFG_RESET;
      irq_mask_r <= {`DTC_IRQ_W{1'b0}};
      alarm_clr_r <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_nxt;
      alarm_clr_r <= bus_wr & (adr == `DTC_REG_CONTROL) & wb_sel_i[0] & wb_dat_i[0];
      if (bus_wr) begin
        // own loop variable, so the read-side loop keeps sole use of j
        for (m = 0; m < 4; m = m + 1) begin
          if (wb_sel_i[m]) begin
            if (adr == `DTC_REG_ASSIGN0) begin
              assign_r[8*m +: 8] <= wb_dat_i[8*m +: 8];
            end
            if (adr == `DTC_REG_ASSIGN1) begin
              assign_r[32+8*m +: 8] <= wb_dat_i[8*m +: 8];
            end
            if (adr == `DTC_REG_CONFIG) begin
              cfg_r[8*m +: 8] <= wb_dat_i[8*m +: 8];
            end
          end
        end
        if (adr == `DTC_REG_IRQ_MASK && wb_sel_i[0]) begin
          irq_mask_r <= wb_dat_i[`DTC_IRQ_W-1:0];
        end
      end
    end
  end

  // sticky events; a new event wins over a write-one clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= {`DTC_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      if (bus_wr && adr == `DTC_REG_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[`DTC_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // command effects, all registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pid_enable_o <= 1'b1;
      analog_inverse_o <= 1'b0;
      pid_inverse_o <= 1'b0;
      power_loss_flag_o <= 1'b0;
      link_priority_o <= 1'b1;
      speed_search_o <= 1'b0;
      forced_decel_o <= 1'b0;
      forced_stop_alarm_o <= 1'b0;
      pid_clear_o <= 1'b0;
      pid_integral_freeze_o <= 1'b0;
      local_select_o <= 1'b0;
      run_request_seen_o <= 1'b0;
      drive_run_o <= 1'b0;
      run_prev_r <= 1'b0;
    end else begin
      pid_enable_o <= pid_on;
      analog_inverse_o <= ana_dir;
      pid_inverse_o <= pid_on & pid_dir;
      power_loss_flag_o <= f_loss[0];
      link_priority_o <= link_lv;
      pid_clear_o <= pid_on & f_clear[0];
      pid_integral_freeze_o <= pid_on & f_freeze[0];
      local_select_o <= f_local[0];
      // decel stays until the alarm takes over or a control-register clear ends it
      forced_decel_o <= (stop_req | forced_decel_o) & ~alarm_nxt & ~alarm_clr_r;
      forced_stop_alarm_o <= alarm_nxt;
      // request-seen only has meaning when a permit terminal exists
      run_request_seen_o <= f_permit[1] & forward_run_i & ~alarm_nxt;
      drive_run_o <= run_ok;
      run_prev_r <= run_ok;
      // latch search choice on the start edge only, held through the run
      if (run_ok && !run_prev_r) begin
        speed_search_o <= f_search[0];
      end else if (!run_ok) begin
        speed_search_o <= 1'b0;
      end
    end
  end

endmodule

// >>> dtc_map.vh
// Purpose: register offsets, fields, reset values and assignment codes for the terminal command logic
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: definitions only
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// assignment codes of the input terminals
`define DTC_CODE_PID_BYPASS 8'h14
`define DTC_CODE_DIR_INVERT 8'h15
`define DTC_CODE_POWER_LOSS 8'h16
`define DTC_CODE_LINK_PRIO 8'h18
`define DTC_CODE_MONITOR 8'h19
`define DTC_CODE_SPEED_SEARCH 8'h1a
`define DTC_CODE_FORCED_STOP 8'h1e
`define DTC_CODE_PID_CLEAR 8'h21
`define DTC_CODE_PID_FREEZE 8'h22
`define DTC_CODE_KEYPAD_SEL 8'h23
`define DTC_CODE_RUN_PERMIT 8'h26

// register byte offsets
`define DTC_REG_ASSIGN0 8'h00
`define DTC_REG_ASSIGN1 8'h04
`define DTC_REG_CONFIG 8'h08
`define DTC_REG_STATE 8'h0c
`define DTC_REG_MONITOR 8'h10
`define DTC_REG_IRQ_STAT 8'h14
`define DTC_REG_IRQ_MASK 8'h18
`define DTC_REG_CONTROL 8'h1c

// config fields
`define DTC_CFG_MANUAL_DIR 0
`define DTC_CFG_PID_MODE_LO 1
`define DTC_CFG_PID_MODE_HI 2
`define DTC_CFG_SECOND_SRC 3
`define DTC_CFG_UPDOWN 4
`define DTC_CFG_RESET 32'h0000_0002

// state fields
`define DTC_ST_PID_EN 0
`define DTC_ST_ANA_DIR 1
`define DTC_ST_PID_DIR 2
`define DTC_ST_POWER_LOSS 3
`define DTC_ST_LINK_PRIO 4
`define DTC_ST_SEARCH 5
`define DTC_ST_DECEL 6
`define DTC_ST_ALARM 7
`define DTC_ST_PID_CLEAR 8
`define DTC_ST_PID_FREEZE 9
`define DTC_ST_LOCAL 10
`define DTC_ST_REQ_SEEN 11
`define DTC_ST_RUN 12

// interrupt events
`define DTC_IRQ_ALARM 0
`define DTC_IRQ_POWER_LOSS 1
`define DTC_IRQ_REQ_SEEN 2
`define DTC_IRQ_W 3

// pid mode values
`define DTC_PID_NORMAL 2'h1
`define DTC_PID_INVERSE 2'h2

`endif

// >>> dtc_terminal_assertions.sv
// Purpose: concurrent checks on the terminal command outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes: sees only the top module ports
`timescale 1ns/10ps
module dtc_terminal_assertions (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire forward_run_i, // run command
  input wire drive_stopped_i, // at zero speed
  input wire pid_enable_o, // pid active
  input wire pid_inverse_o, // pid inverse
  input wire speed_search_o, // search chosen
  input wire forced_decel_o, // forced decel
  input wire forced_stop_alarm_o, // alarm
  input wire pid_clear_o, // pid clear
  input wire pid_integral_freeze_o, // pid freeze
  input wire run_request_seen_o, // request seen
  input wire drive_run_o // running
);
  // one domain, so the clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request seen and run both need the run command of the previous edge
  property p_seen; run_request_seen_o |-> $past(forward_run_i); endproperty
  a_seen: assert property (p_seen) else $error("seen without run");
  property p_run; drive_run_o |-> $past(forward_run_i) && !$past(forced_stop_alarm_o); endproperty
  a_run: assert property (p_run) else $error("run without cause");
  // alarm only once stopped during forced decel
  property p_alm; $rose(forced_stop_alarm_o) |-> $past(forced_decel_o) && $past(drive_stopped_i);
  endproperty
  a_alm: assert property (p_alm) else $error("alarm without stop");
  property p_dec; forced_decel_o && drive_stopped_i |=> !forced_decel_o && forced_stop_alarm_o;
  endproperty
  a_dec: assert property (p_dec) else $error("decel did not end in alarm");
  // with pid bypassed its outputs stay quiet
  property p_byp_inv; !pid_enable_o |-> !pid_inverse_o; endproperty
  a_byp_inv: assert property (p_byp_inv) else $error("pid inverse while bypassed");
  property p_byp_clr; pid_clear_o |-> pid_enable_o; endproperty
  a_byp_clr: assert property (p_byp_clr) else $error("pid clear while bypassed");
  property p_byp_frz; pid_integral_freeze_o |-> pid_enable_o; endproperty
  a_byp_frz: assert property (p_byp_frz) else $error("pid freeze while bypassed");
  property p_srch; speed_search_o |-> drive_run_o; endproperty
  a_srch: assert property (p_srch) else $error("search while stopped");
endmodule
bind dtc_terminal dtc_terminal_assertions dtc_terminal_assertions_i (.clk_i(clk_i),
  .rst_i(rst_i), .forward_run_i(forward_run_i), .drive_stopped_i(drive_stopped_i),
  .pid_enable_o(pid_enable_o), .pid_inverse_o(pid_inverse_o), .speed_search_o(speed_search_o),
  .forced_decel_o(forced_decel_o), .forced_stop_alarm_o(forced_stop_alarm_o),
  .pid_clear_o(pid_clear_o), .pid_integral_freeze_o(pid_integral_freeze_o),
  .run_request_seen_o(run_request_seen_o), .drive_run_o(drive_run_o));

// >>> dtc_upper.sv
// Purpose: upper equipment that grants run permit
// Assumes: permit drives one terminal of the block
// Notes: preparation time set per run, so prompt and slow answers are both possible
`timescale 1ns/10ps
module dtc_upper (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire [3:0] prep_i, // preparation cycles
  input wire run_request_seen_i, // drive has the run command
  output reg run_permit_o // permit to the drive
);
  reg [3:0] cnt_r;
  // permit only after request seen and preparation done; dropped with the request
  always @(posedge clk_i) begin
    if (rst_i || !run_request_seen_i) begin
      cnt_r <= 4'h0;
      run_permit_o <= 1'b0;
    end else if (cnt_r >= prep_i) begin
      run_permit_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// >>> drive_terminal_command_logic_bench.sv
// Purpose: directed bench for the terminal command logic
// Assumes: terminal 3 carries the permit of the upper equipment
// Notes: ack sampled at the rising edge, levels at the falling edge, inputs driven on the rise
`timescale 1ns/10ps
`include "dtc_map.vh"
module drive_terminal_command_logic_bench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] tb_term = 8'h10;
  reg forward_run = 1'b0;
  reg stopped = 1'b0;
  reg we = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg [3:0] prep = 4'h6;
  reg [31:0] adr = 32'h0;
  reg [31:0] wd = 32'h0;
  reg [31:0] q;
  wire [31:0] rdat;
  wire ack, irq, pen, ainv, pinv, loss, link, srch, dec, alm, clr, frz, keypad_source_select, seen, run, permit;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer n;
  always #5 clk_i = ~clk_i;
  dtc_terminal dtc_terminal_i (.clk_i(clk_i), .rst_i(rst_i),
    .term_i({tb_term[7:4], permit, tb_term[2:0]}), .forward_run_i(forward_run),
    .drive_stopped_i(stopped), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .pid_enable_o(pen), .analog_inverse_o(ainv), .pid_inverse_o(pinv),
    .power_loss_flag_o(loss), .link_priority_o(link), .speed_search_o(srch),
    .forced_decel_o(dec), .forced_stop_alarm_o(alm), .pid_clear_o(clr),
    .pid_integral_freeze_o(frz), .local_select_o(keypad_source_select), .run_request_seen_o(seen),
    .drive_run_o(run));
  dtc_upper dtc_upper_i (.clk_i(clk_i), .rst_i(rst_i), .prep_i(prep),
    .run_request_seen_i(seen), .run_permit_o(permit));
  task end_sim;
    begin
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // one classic cycle; request held until ack is seen at a rising edge, released there
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {24'h0, a}; wd <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin @(posedge clk_i); n = n + 1; end
      if (n == 20) begin fail_count = fail_count + 1; end_sim; end
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
    end
  endtask
  task settle; repeat (3) @(negedge clk_i); endtask
  task wait_run;
    begin
      n = 0;
      while (run !== 1'b1 && n < 40) begin @(negedge clk_i); n = n + 1; end
      if (n == 40) begin fail_count = fail_count + 1; end_sim; end
    end
  endtask
  // directed sequence; forced-stop terminal 4 is kept high until its own test
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `DTC_REG_CONFIG, 0); chk(q, 32'h2);
    bus(0, 8'h3c, 0); chk(q, 32'h0);
    settle; chk(pen, 1); chk(link, 1);
    bus(1, `DTC_REG_ASSIGN0, 32'h26181514);
    bus(1, `DTC_REG_ASSIGN1, 32'h1621191e);
    @(posedge clk_i) tb_term <= 8'h12;
    settle; chk(link, 0); chk(ainv, 1); chk(pinv, 1);
    bus(1, `DTC_REG_CONFIG, 32'h3); settle; chk(ainv, 0);
    bus(1, `DTC_REG_CONFIG, 32'ha); settle; chk(ainv, 0);
    bus(1, `DTC_REG_CONFIG, 32'h4); settle; chk(pinv, 0);
    @(posedge clk_i) tb_term <= 8'h17;
    bus(1, `DTC_REG_CONFIG, 32'h3);
    settle; chk(pen, 0); chk(pinv, 0); chk(ainv, 1);
    @(posedge clk_i) tb_term <= 8'hb0;
    settle; chk(loss, 1);
    bus(0, `DTC_REG_MONITOR, 0); chk(q, 32'h20);
    bus(1, `DTC_REG_IRQ_MASK, 32'h2); settle; chk(irq, 1);
    bus(1, `DTC_REG_IRQ_STAT, 32'h2); settle; chk(irq, 0);
    bus(1, `DTC_REG_IRQ_MASK, 32'h0);
    @(posedge clk_i) forward_run <= 1'b1;
    settle; chk(seen, 1); chk(run, 0);
    wait_run; chk(permit, 1);
    @(posedge clk_i) forward_run <= 1'b0;
    settle; chk(seen, 0); chk(run, 0);
    @(posedge clk_i) tb_term <= 8'h50;
    settle; chk(clr, 1);
    @(posedge clk_i) tb_term <= 8'h00;
    settle; chk(dec, 1); chk(alm, 0);
    @(posedge clk_i) stopped <= 1'b1;
    settle; chk(alm, 1); chk(dec, 0);
    @(posedge clk_i) stopped <= 1'b0;
    bus(1, `DTC_REG_CONTROL, 32'h1); settle; chk(alm, 0);
    @(posedge clk_i) tb_term <= 8'hf0;
    bus(1, `DTC_REG_ASSIGN1, 32'h1a23221e);
    settle; chk(frz, 1); chk(keypad_source_select, 1);
    @(posedge clk_i) begin prep <= 4'h0; forward_run <= 1'b1; end
    wait_run; chk(srch, 1);
    end_sim;
  end
endmodule
